// *** verilog/spi_fault_pkg.sv ***
// Purpose: Shared constants and carrier types for the serial port start, error and request logic.
// Assumes: Byte-wide frames, one bus clock at 250 MHz.
// Notes: Divider table gives half-bit lengths in bus cycles, minus one.
package spi_fault_pkg;
    localparam int DATA_W = 8;
    localparam int TX_FIFO_DEPTH = 4;
    localparam int DIV_W = 6;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] LAST_HALF = 4'hf;
    localparam logic [CNT_W-1:0] LAST_CAPTURE = 4'h7;
    localparam logic [CNT_W-1:0] ALL_CAPTURED = 4'h8;
    localparam logic [CNT_W-1:0] FIRST_STEP = 4'h0;
    localparam int PIN_SCLK = 0;
    localparam int PIN_SEL = 1;
    localparam int PIN_MOSI = 2;
    localparam int PIN_MISO = 3;
    localparam int PIN_N = 4;
    localparam logic [1:0] RATE_DIV2 = 2'h0;
    localparam logic [1:0] RATE_DIV8 = 2'h1;
    localparam logic [1:0] RATE_DIV32 = 2'h2;
    localparam logic [DIV_W-1:0] HALF_DIV2 = 6'h00;
    localparam logic [DIV_W-1:0] HALF_DIV8 = 6'h03;
    localparam logic [DIV_W-1:0] HALF_DIV32 = 6'h0f;
    localparam logic [DIV_W-1:0] HALF_DIV128 = 6'h3f;

    typedef struct packed {
        logic moduleEnable;
        logic masterSelect;
        logic clockPolarity;
        logic clockPhase;
        logic txIrqEnable;
        logic rxIrqEnable;
    } control_type;

    typedef struct packed {
        logic selectFaultEnable;
        logic errorIrqEnable;
        logic [1:0] bitRateSelect;
    } status_ctl_type;

    localparam control_type CONTROL_RESET = '0;
    localparam status_ctl_type STATUS_CTL_RESET = '0;

    typedef struct packed {
        logic txEmptyFlag;
        logic rxFullFlag;
        logic overrunFlag;
        logic selectFaultFlag;
    } flags_type;

    typedef enum logic [1:0] {IDLE, MASTER_RUN, SLAVE_RUN} xfer_state_type;

    function automatic logic [DIV_W-1:0] halfDivMax(input logic [1:0] sel);
        case (sel)
            RATE_DIV2: halfDivMax = HALF_DIV2;
            RATE_DIV8: halfDivMax = HALF_DIV8;
            RATE_DIV32: halfDivMax = HALF_DIV32;
            default: halfDivMax = HALF_DIV128;
        endcase
    endfunction
endpackage

// *** verilog/spi_start_error_irq_logic.sv ***
// Purpose: Serial port transfer start, overrun and select-fault detection, request outputs.
// Assumes: CPU strobes are one-cycle pulses on core_clk; pins are asynchronous.
// Notes: Pin inputs pass three flops, so slave clocks must stay well below core_clk / 8.
// Operation
// - In master mode a data write starts a transfer; phase does not alter delay.
// - Phase zero keeps serial clock idle for the first half bit.
// - Phase one opens the first bit with an idle-to-active clock edge.
// - Bit-rate divider runs only with module enable and master select both set.
// - Start delay after a master write is at most one bit time.
// - Master clock edges are registered on the rising edge of the bus clock.
// - Overrun sets if receive data is unread at first capture of next transfer.
// - During overrun new bytes are dropped; the old byte stays readable.
// - Overrun clears by status read followed by data read.
// - One error enable passes both overrun and select fault to the shared request.
// - Select fault sets only while its enable is set; clearing enable keeps it.
// - Master drives clock and MOSI, reads MISO; slave reverses.
// - Master sees select low: fault, disable, transmit empty, counter clear, pins released.
// - Slave select rising during a transfer sets the select fault.
// - Phase zero select then deselect faults without clocks; phase one does not.
// - A slave fault keeps enable and master select; only raises the error request.
// - Deselected slave floats MISO and ignores serial clock edges.
// - Select fault clears by flagged status read then control write, with no fault.
// - Transmit request is empty flag and transmit enable and module enable.
// - Receive request is full flag and receive enable and module enable.
// - Receive full sets per byte received; transmit empty is set while the transmit queue has a free slot.
// - Receive full, overrun and select fault share one request output.
// - Receive full clears by flagged status read followed by data read.
// - Module enable low aborts, clears shifter and counter, sets transmit empty.
`timescale 1ns/1ps
`default_nettype none

module spi_tx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rstN,
    input wire logic flush,
    input wire logic inValid,
    input wire logic [WIDTH-1:0] inData,
    output logic inReady,
    output logic outValid,
    output logic [WIDTH-1:0] outData,
    input wire logic outReady
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PTR_W:0] FULL_COUNT = (PTR_W+1)'(DEPTH);
    localparam logic [PTR_W-1:0] LAST_SLOT = PTR_W'(DEPTH - 1);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wrPtr_q, rdPtr_q;
    logic [PTR_W:0] count_q;
    logic push, pop;

    function automatic logic [PTR_W-1:0] nextPtr(input logic [PTR_W-1:0] p);
        nextPtr = (p == LAST_SLOT) ? '0 : p + 1'b1;
    endfunction

    assign inReady = (count_q != FULL_COUNT);
    assign outValid = (count_q != '0);
    assign outData = mem[rdPtr_q];
    assign push = inValid && inReady && !flush;
    assign pop = outValid && outReady && !flush;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr_q] <= inData;
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else if (flush) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wrPtr_q <= nextPtr(wrPtr_q);
            end
            if (pop) begin
                rdPtr_q <= nextPtr(rdPtr_q);
            end
            count_q <= count_q + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
        end
    end
endmodule

module spi_start_error_irq_logic #(
    parameter int FIFO_DEPTH = spi_fault_pkg::TX_FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic controlWrite,
    input wire spi_fault_pkg::control_type controlIn,
    input wire logic statusCtlWrite,
    input wire spi_fault_pkg::status_ctl_type statusCtlIn,
    input wire logic statusRead,
    input wire logic dataWrite,
    input wire logic [spi_fault_pkg::DATA_W-1:0] dataIn,
    input wire logic dataRead,
    output spi_fault_pkg::control_type controlOut,
    output spi_fault_pkg::flags_type flagsOut,
    output logic [spi_fault_pkg::DATA_W-1:0] rxData,
    output logic txIrq,
    output logic rxErrorIrq,
    input wire logic sclkIn,
    output logic sclkOut,
    output logic sclkEnN,
    input wire logic mosiIn,
    output logic mosiOut,
    output logic mosiEnN,
    input wire logic misoIn,
    output logic misoOut,
    output logic misoEnN,
    input wire logic selectN
);
    localparam int W = spi_fault_pkg::DATA_W;
    logic [1:0] rstPipe_q;
    logic rstN;
    logic [spi_fault_pkg::PIN_N-1:0] pinS1_q, pinS2_q, pinS3_q, pinSt_q, pinSt_d;
    spi_fault_pkg::control_type ctl_q;
    spi_fault_pkg::status_ctl_type sc_q;
    spi_fault_pkg::xfer_state_type state_q;
    logic [spi_fault_pkg::DIV_W-1:0] divCnt_q;
    logic bitPhase_q, halfTick, rateOn;
    logic [spi_fault_pkg::CNT_W-1:0] halfCnt_q, capCnt_q;
    logic [W-1:0] shift_q, rxData_q, doneByte, fifoData;
    logic rxFull_q, overrun_q, fault_q, armRx_q, armOvr_q, armFault_q;
    logic fifoValid, fifoInReady, fifoPop, txEmpty_q;
    logic outBit_q, sclkOut_q, sclkEnN_q, mosiEnN_q, misoEnN_q, txIrq_q, rxErrIrq_q;
    logic en, master, clock_phase, cpol, sclkChg, leading, trailing, selLow, selFall, selRise;
    logic slaveOn, capEv, drvEv, startEv, doneEv, firstCap, capIn;
    logic masterFault, slaveFault, quiesce, ovrSet;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rstPipe_q <= 2'h0;
        end else begin
            rstPipe_q <= {rstPipe_q[0], 1'b1};
        end
    end
    assign rstN = rstPipe_q[1];

    // A pin change counts once the second and third stages agree
    always_comb begin
        pinSt_d = (pinS2_q & pinS3_q) | (pinSt_q & (pinS2_q ^ pinS3_q));
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            pinS1_q <= 4'h2;
            pinS2_q <= 4'h2;
            pinS3_q <= 4'h2;
            pinSt_q <= 4'h2;
        end else begin
            pinS1_q <= {misoIn, mosiIn, selectN, sclkIn};
            pinS2_q <= pinS1_q;
            pinS3_q <= pinS2_q;
            pinSt_q <= pinSt_d;
        end
    end

    always_comb begin
        en = ctl_q.moduleEnable;
        master = ctl_q.masterSelect;
        clock_phase = ctl_q.clockPhase;
        cpol = ctl_q.clockPolarity;
        sclkChg = pinSt_d[spi_fault_pkg::PIN_SCLK] != pinSt_q[spi_fault_pkg::PIN_SCLK];
        leading = sclkChg && (pinSt_d[spi_fault_pkg::PIN_SCLK] != cpol);
        trailing = sclkChg && (pinSt_d[spi_fault_pkg::PIN_SCLK] == cpol);
        selLow = !pinSt_d[spi_fault_pkg::PIN_SEL];
        selFall = pinSt_q[spi_fault_pkg::PIN_SEL] && selLow;
        selRise = !pinSt_q[spi_fault_pkg::PIN_SEL] && !selLow;
        rateOn = en && master;
        halfTick = rateOn && (divCnt_q == spi_fault_pkg::halfDivMax(sc_q.bitRateSelect));
        slaveOn = en && !master && selLow;
        capIn = master ? pinSt_d[spi_fault_pkg::PIN_MISO] : pinSt_d[spi_fault_pkg::PIN_MOSI];
        masterFault = rateOn && sc_q.selectFaultEnable && selLow;
        // Phase zero counts select low as a transfer already running
        slaveFault = en && !master && sc_q.selectFaultEnable && selRise && (state_q == spi_fault_pkg::SLAVE_RUN);
        quiesce = !en || masterFault;
        startEv = 1'b0;
        capEv = 1'b0;
        drvEv = 1'b0;
        doneEv = 1'b0;
        firstCap = 1'b0;
        doneByte = shift_q;
        case (state_q)
            spi_fault_pkg::IDLE: begin
                if (master) begin
                    // Only on a whole-bit boundary: delay is at most one bit time
                    startEv = halfTick && bitPhase_q && fifoValid;
                end else begin
                    startEv = slaveOn && (clock_phase ? leading : selFall);
                end
            end
            spi_fault_pkg::MASTER_RUN: begin
                capEv = halfTick && !halfCnt_q[0];
                drvEv = halfTick && halfCnt_q[0] && (halfCnt_q != spi_fault_pkg::LAST_HALF);
                doneEv = halfTick && (halfCnt_q == spi_fault_pkg::LAST_HALF);
                firstCap = capEv && (halfCnt_q == spi_fault_pkg::FIRST_STEP);
            end
            spi_fault_pkg::SLAVE_RUN: begin
                capEv = slaveOn && (clock_phase ? trailing : leading);
                drvEv = slaveOn && (clock_phase ? leading : trailing) && (capCnt_q != spi_fault_pkg::ALL_CAPTURED);
                doneEv = slaveOn && (clock_phase ? (trailing && capCnt_q == spi_fault_pkg::LAST_CAPTURE)
                                          : (trailing && capCnt_q == spi_fault_pkg::ALL_CAPTURED));
                firstCap = capEv && (capCnt_q == spi_fault_pkg::FIRST_STEP);
                if (clock_phase) begin
                    doneByte = {shift_q[W-2:0], capIn};
                end
            end
            default: begin
                startEv = 1'b0;
            end
        endcase
        fifoPop = startEv && fifoValid && !quiesce;
        ovrSet = firstCap && rxFull_q;
    end

    spi_tx_fifo #(.WIDTH(W), .DEPTH(FIFO_DEPTH)) txFifo (
        .clk(core_clk),
        .rstN(rstN),
        .flush(quiesce),
        .inValid(dataWrite),
        .inData(dataIn),
        .inReady(fifoInReady),
        .outValid(fifoValid),
        .outData(fifoData),
        .outReady(fifoPop)
    );

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            ctl_q <= spi_fault_pkg::CONTROL_RESET;
            sc_q <= spi_fault_pkg::STATUS_CTL_RESET;
        end else begin
            if (controlWrite) begin
                ctl_q <= controlIn;
            end
            // Hardware disable wins over a write in the same cycle
            if (masterFault) begin
                ctl_q.moduleEnable <= 1'b0;
            end
            if (statusCtlWrite) begin
                sc_q <= statusCtlIn;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            divCnt_q <= '0;
            bitPhase_q <= 1'b0;
        end else if (!rateOn) begin
            divCnt_q <= '0;
            bitPhase_q <= 1'b0;
        end else if (halfTick) begin
            divCnt_q <= '0;
            bitPhase_q <= !bitPhase_q;
        end else begin
            divCnt_q <= divCnt_q + 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            state_q <= spi_fault_pkg::IDLE;
            halfCnt_q <= '0;
            capCnt_q <= '0;
        end else if (quiesce || slaveFault || (state_q == spi_fault_pkg::SLAVE_RUN && !selLow)) begin
            state_q <= spi_fault_pkg::IDLE;
            halfCnt_q <= '0;
            capCnt_q <= '0;
        end else if (startEv) begin
            state_q <= master ? spi_fault_pkg::MASTER_RUN : spi_fault_pkg::SLAVE_RUN;
            halfCnt_q <= '0;
            capCnt_q <= '0;
        end else if (doneEv) begin
            state_q <= spi_fault_pkg::IDLE;
            halfCnt_q <= '0;
            capCnt_q <= '0;
        end else begin
            if (halfTick && state_q == spi_fault_pkg::MASTER_RUN) begin
                halfCnt_q <= halfCnt_q + 1'b1;
            end
            if (capEv && state_q == spi_fault_pkg::SLAVE_RUN) begin
                capCnt_q <= capCnt_q + 1'b1;
            end
        end
    end

    // Captures shift in at once, so the top bit is always the next one to send
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            shift_q <= '0;
            outBit_q <= 1'b0;
        end else if (quiesce) begin
            shift_q <= '0;
            outBit_q <= 1'b0;
        end else if (startEv) begin
            // With nothing queued the last byte received into the shifter goes out
            shift_q <= fifoValid ? fifoData : shift_q;
            outBit_q <= fifoValid ? fifoData[W-1] : shift_q[W-1];
        end else begin
            if (capEv) begin
                shift_q <= {shift_q[W-2:0], capIn};
            end
            if (drvEv) begin
                outBit_q <= shift_q[W-1];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            sclkOut_q <= 1'b0;
        end else if (quiesce || state_q != spi_fault_pkg::MASTER_RUN) begin
            sclkOut_q <= startEv && master && !quiesce ? (cpol ^ clock_phase) : cpol;
        end else if (halfTick) begin
            // Edges are registered on the tick and launch at the bus-clock rising edge
            sclkOut_q <= doneEv ? cpol : !sclkOut_q;
        end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            sclkEnN_q <= 1'b1;
            mosiEnN_q <= 1'b1;
            misoEnN_q <= 1'b1;
        end else begin
            sclkEnN_q <= !(rateOn && !masterFault);
            mosiEnN_q <= !(rateOn && !masterFault);
            misoEnN_q <= !slaveOn;
        end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            rxData_q <= '0;
            rxFull_q <= 1'b0;
            armRx_q <= 1'b0;
        end else begin
            if (doneEv && !overrun_q && !ovrSet) begin
                rxData_q <= doneByte;
            end
            armRx_q <= dataRead ? 1'b0 : (armRx_q || (statusRead && rxFull_q));
            // A byte landing in the clearing cycle keeps the flag set
            rxFull_q <= (doneEv && !overrun_q && !ovrSet) || (rxFull_q && !(dataRead && armRx_q));
        end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            overrun_q <= 1'b0;
            armOvr_q <= 1'b0;
        end else begin
            armOvr_q <= dataRead ? 1'b0 : (armOvr_q || (statusRead && overrun_q));
            overrun_q <= ovrSet || (overrun_q && !(dataRead && armOvr_q));
        end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            fault_q <= 1'b0;
            armFault_q <= 1'b0;
        end else begin
            if (controlWrite || masterFault || slaveFault) begin
                armFault_q <= 1'b0;
            end else if (statusRead && fault_q) begin
                armFault_q <= 1'b1;
            end
            fault_q <= masterFault || slaveFault
                || (fault_q && !(controlWrite && armFault_q));
        end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            txEmpty_q <= 1'b1;
            txIrq_q <= 1'b0;
            rxErrIrq_q <= 1'b0;
        end else begin
            txEmpty_q <= fifoInReady || quiesce;
            txIrq_q <= txEmpty_q && ctl_q.txIrqEnable && en;
            rxErrIrq_q <= (rxFull_q && ctl_q.rxIrqEnable && en)
                || (sc_q.errorIrqEnable && (overrun_q || fault_q));
        end
    end

    assign controlOut = ctl_q;
    assign flagsOut = '{txEmptyFlag: txEmpty_q, rxFullFlag: rxFull_q,
                        overrunFlag: overrun_q, selectFaultFlag: fault_q};
    assign rxData = rxData_q;
    assign txIrq = txIrq_q;
    assign rxErrorIrq = rxErrIrq_q;
    assign sclkOut = sclkOut_q;
    assign sclkEnN = sclkEnN_q;
    assign mosiOut = outBit_q;
    assign mosiEnN = mosiEnN_q;
    assign misoOut = outBit_q;
    assign misoEnN = misoEnN_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstN);

    sequence masterShutdown;
        !ctl_q.moduleEnable && state_q == spi_fault_pkg::IDLE ##1 txEmpty_q && sclkEnN_q;
    endsequence

    a_start_within_bit: assert property (state_q == spi_fault_pkg::IDLE && rateOn && fifoValid
        && !masterFault |-> ##[0:130] (state_q != spi_fault_pkg::IDLE || !rateOn || !fifoValid))
        else $error("master start later than one bit");
    a_divider_gated: assert property (!rateOn |=> divCnt_q == '0 && !bitPhase_q)
        else $error("divider ran while disabled");
    a_phase0_idle_half: assert property (startEv && master && !clock_phase && !quiesce |=> sclkOut_q == cpol)
        else $error("phase zero clock left idle early");
    a_phase1_first_edge: assert property (startEv && master && clock_phase && !quiesce |=> sclkOut_q != cpol)
        else $error("phase one missing opening edge");
    a_overrun_sets: assert property (ovrSet |=> overrun_q)
        else $error("overrun not flagged");
    // A data read in the same cycle may still clear the full flag; only a new set is barred
    a_overrun_holds_data: assert property (overrun_q && doneEv
        |=> $stable(rxData_q) && (!rxFull_q || $past(rxFull_q)))
        else $error("byte accepted during overrun");
    a_fault_needs_enable: assert property (!sc_q.selectFaultEnable && !fault_q |=> !fault_q)
        else $error("select fault set while disabled");
    a_master_fault_stop: assert property (masterFault |=> masterShutdown)
        else $error("master fault did not shut down");
    a_slave_fault_keeps: assert property (slaveFault && !controlWrite
        |=> ctl_q.moduleEnable && ctl_q == $past(ctl_q))
        else $error("slave fault altered control");
    a_miso_released: assert property (!selLow && $past(!selLow) |-> ##1 misoEnN_q)
        else $error("deselected slave drives miso");
    a_error_request: assert property (sc_q.errorIrqEnable && (overrun_q || fault_q) |=> rxErrorIrq)
        else $error("error request missing");
endmodule

`default_nettype wire

// *** tb/spi_slave_model.sv ***
// Purpose: Far-side serial slave, clock phase 0 and idle-low clock, one byte per select.
// Assumes: Byte reloaded from txByte each time sel rises.
// Notes: Released data line shows the inverse of the last bit, never a stale copy.
`timescale 1ns/1ps
`default_nettype none
module spi_slave_model (
    input wire logic sclk,
    input wire logic mosi,
    input wire logic sel,
    input wire logic [7:0] txByte,
    output logic miso,
    output logic [7:0] rxByte
);
    logic [7:0] sh = 8'h00;
    logic last = 1'b0;
    initial rxByte = 8'h00;
    always @(posedge sel) sh = txByte;
    always @(posedge sclk) if (sel) rxByte = {rxByte[6:0], mosi};
    always @(negedge sclk) if (sel) sh = {sh[6:0], 1'b0};
    always @(sel or sh) begin
        if (sel) begin
            miso = sh[7];
            last = sh[7];
        end else miso = ~last;
    end
endmodule
`default_nettype wire

// *** tb/test_spi_start_error_irq_logic.sv ***
// Purpose: Directed checks of master start, overrun, select fault and request outputs.
// Assumes: Bit rate at divide by 32 so the synchronised sample has margin.
// Notes: Strobes are driven by one task; each leaves idle edges before returning.
`timescale 1ns/1ps
`default_nettype none
module test_spi_start_error_irq_logic;
    localparam int CTL = 0, SCTL = 1, WR = 2, RS = 3, RD = 4;
    logic core_clk = 1'b0, rst_n = 1'b0, controlWrite = 1'b0, statusCtlWrite = 1'b0, statusRead = 1'b0;
    logic dataWrite = 1'b0, dataRead = 1'b0, sclkIn = 1'b0, mosiIn = 1'b0, selectN = 1'b1, partnerSel = 1'b0;
    spi_fault_pkg::control_type controlIn = '0, controlOut;
    spi_fault_pkg::status_ctl_type statusCtlIn = '0;
    spi_fault_pkg::flags_type flagsOut;
    logic [7:0] dataIn = 8'h00, rxData, partnerTx = 8'h00, partnerRx;
    logic txIrq, rxErrorIrq, sclkOut, sclkEnN, mosiOut, mosiEnN, misoOut, misoEnN, partnerMiso, misoPin;
    int n_mismatch = 0, samples_checked = 0, waited;
    assign misoPin = misoEnN ? partnerMiso : misoOut;
    always #2 core_clk = ~core_clk;
    spi_start_error_irq_logic spi_start_error_irq_logic_inst (.core_clk, .rst_n, .controlWrite, .controlIn,
        .statusCtlWrite, .statusCtlIn, .statusRead, .dataWrite, .dataIn, .dataRead, .controlOut, .flagsOut,
        .rxData, .txIrq, .rxErrorIrq, .sclkIn, .sclkOut, .sclkEnN, .mosiIn, .mosiOut, .mosiEnN,
        .misoIn(misoPin), .misoOut, .misoEnN, .selectN);
    spi_slave_model spi_slave_model_inst (.sclk(sclkOut), .mosi(mosiOut), .sel(partnerSel),
        .txByte(partnerTx), .miso(partnerMiso), .rxByte(partnerRx));
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic cpu(input int op, input logic [7:0] v);
        @(posedge core_clk);
        case (op)
            CTL: begin
                controlWrite <= 1'b1;
                controlIn <= spi_fault_pkg::control_type'(v[5:0]);
            end
            SCTL: begin
                statusCtlWrite <= 1'b1;
                statusCtlIn <= spi_fault_pkg::status_ctl_type'(v[3:0]);
            end
            WR: begin
                dataWrite <= 1'b1;
                dataIn <= v;
            end
            RS: statusRead <= 1'b1;
            default: dataRead <= 1'b1;
        endcase
        @(posedge core_clk);
        {controlWrite, statusCtlWrite, dataWrite, statusRead, dataRead} <= 5'h00;
        tick(3);
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic waitBit(input int idx);
        waited = 0;
        while (flagsOut[idx] !== 1'b1 && waited < 2000) begin
            tick(1);
            waited++;
        end
        if (waited >= 2000) begin
            n_mismatch++;
            $display("mismatch at %0t: flag %0d never set", $time, idx);
        end
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #100000;
        n_mismatch++;
        end_of_test();
    end
    initial begin
        tick(2);
        rst_n <= 1'b1;
        tick(4);
        check(flagsOut, 8'h08);
        check({txIrq, rxErrorIrq, sclkEnN, mosiEnN, misoEnN}, 8'h07);
        $display("test reset done");
        cpu(SCTL, 8'h06);
        cpu(CTL, 8'h31);
        partnerTx <= 8'h3c;
        partnerSel <= 1'b1;
        cpu(WR, 8'ha5);
        waitBit(2);
        tick(3);
        check(waited < 300, 8'h01);
        check(rxData, 8'h3c);
        check(partnerRx, 8'ha5);
        check({sclkEnN, mosiEnN, misoEnN}, 8'h01);
        check({txIrq, rxErrorIrq}, 8'h01);
        partnerSel <= 1'b0;
        partnerTx <= 8'h5a;
        tick(2);
        partnerSel <= 1'b1;
        cpu(WR, 8'h11);
        waitBit(1);
        tick(300);
        check({flagsOut.overrunFlag, rxErrorIrq}, 8'h03);
        check(rxData, 8'h3c);
        check(partnerRx, 8'h11);
        cpu(RS, 8'h00);
        cpu(RD, 8'h00);
        tick(2);
        check({flagsOut, rxErrorIrq}, 8'h10);
        $display("test master transfer done");
        cpu(CTL, 8'h33);
        tick(2);
        check(txIrq, 8'h01);
        cpu(CTL, 8'h13);
        tick(2);
        check({txIrq, flagsOut.txEmptyFlag}, 8'h01);
        partnerSel <= 1'b0;
        cpu(SCTL, 8'h02);
        cpu(CTL, 8'h30);
        selectN <= 1'b0;
        tick(8);
        check(flagsOut.selectFaultFlag, 8'h00);
        selectN <= 1'b1;
        tick(6);
        cpu(SCTL, 8'h0e);
        selectN <= 1'b0;
        tick(8);
        check({flagsOut.selectFaultFlag, controlOut.moduleEnable, flagsOut.txEmptyFlag, sclkEnN}, 8'h0b);
        check(rxErrorIrq, 8'h01);
        selectN <= 1'b1;
        tick(6);
        cpu(RS, 8'h00);
        cpu(CTL, 8'h20);
        check(flagsOut.selectFaultFlag, 8'h00);
        $display("test master fault done");
        cpu(WR, 8'h96);
        selectN <= 1'b0;
        tick(8);
        check({misoEnN, misoOut}, 8'h01);
        selectN <= 1'b1;
        tick(8);
        check({flagsOut.selectFaultFlag, controlOut.moduleEnable, misoEnN}, 8'h07);
        cpu(RS, 8'h00);
        cpu(CTL, 8'h24);
        selectN <= 1'b0;
        tick(8);
        selectN <= 1'b1;
        tick(8);
        check(flagsOut.selectFaultFlag, 8'h00);
        $display("test slave fault done");
        end_of_test();
    end
endmodule
`default_nettype wire
